// ===== rtl/stc_pkg.sv
// types shared by the tx channel control
package stc_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } stc_req_type;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_HOLD  = 3'b001,
    ST_FETCH = 3'b011,
    ST_BYTE  = 3'b010,
    ST_SEND  = 3'b110,
    ST_DONE  = 3'b111
  } stc_state_type;
endpackage

// ===== rtl/stc_regs.svh
// register offsets, control fields, reset values and timing for the tx channel control
`ifndef STC_REGS_SVH
`define STC_REGS_SVH
`define STC_OFS_CTRL    8'h1c
`define STC_OFS_LEN     8'h20
`define STC_OFS_LEVEL   8'h24
`define STC_OFS_AE      8'h28
`define STC_OFS_THR     8'h2c
`define STC_OFS_RXCTRL  8'h34
`define STC_OFS_STATUS  8'h38
`define STC_B_RUN       0
`define STC_B_AUTOCLR   1
`define STC_B_DONE_EN   2
`define STC_B_AE_EN     3
`define STC_B_UNF_EN    4
`define STC_B_REVERSE   5
`define STC_B_LVL_EN    6
`define STC_B_BYTE_MODE 7
`define STC_B_MODE8     8
`define STC_B_MODE9     9
`define STC_B_MODE10    10
`define STC_B_PROBE     11
`define STC_RATE_LSB    16
`define STC_RATE_MSB    27
`define STC_S_DONE      0
`define STC_S_AE        1
`define STC_S_UNF       2
`define STC_S_LVL       3
`define STC_S_BUSY      4
`define STC_LEN_WORDS   29:0
`define STC_LEN_LAST    31:30
`define STC_RST_WORD    32'h0000_0000
`define STC_UART_BASE   4'ha
`define STC_UPL_BITS    4'h8
`endif

// ===== rtl/stc_tx_channel.sv
// tx channel control: fifo, registers, sequencer, uart and bi-phase encoders
`timescale 1ns/1ps
`include "stc_regs.svh"

module stc_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // fill side
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  // drain side
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [W-1:0]              out_data,
  output logic [$clog2(D+1)-1:0]    level
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic          room_q;
  logic          empty_q;
  wire push = in_valid && room_q;
  wire pop  = out_ready && !empty_q;
  wire [CW-1:0] cnt_d = cnt_q + CW'(push) - CW'(pop);

  generate
    if (D < 2 || (1 << AW) != D)
    begin : g_chk
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wp_q] <= in_data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wp_q    <= '0;
      rp_q    <= '0;
      cnt_q   <= '0;
      room_q  <= 1'b1;
      empty_q <= 1'b1;
    end
    else
    begin
      wp_q    <= wp_q + AW'(push);
      rp_q    <= rp_q + AW'(pop);
      cnt_q   <= cnt_d;
      room_q  <= cnt_d != CW'(D);
      empty_q <= cnt_d == '0;
    end
  end

  assign in_ready  = room_q;
  assign out_valid = !empty_q;
  assign out_data  = mem[rp_q];
  assign level     = cnt_q;
endmodule // stc_fifo

// How it works
// - run enable starts the sequencer; while clear nothing new begins
// - start waits until summed fifo path count reaches the start threshold
// - with auto-clear the sequencer drops run enable after each transfer
// - each finished packet sets done status, interrupting when its enable is set
// - falling to or below almost-empty total sets a sticky status and interrupt
// - needing a word in packet mode while the fifo is empty sets sticky underflow
// - underflow interrupt is underflow status anded with its enable
// - byte lanes go low first, or high first when lane order reverses
// - while the path count is below almost-empty total, level interrupt asserts
// - single byte mode sends only the first lane of each word
// - single byte mode ignores packet length, sending as words arrive
// - packet mode sends exactly the programmed length back to back
// - on the uart channel the probe bit puts the divided clock on the line
// - bi-phase-level coding, one is high then low; invert flips the stream
// - uart sends two stop bits when selected, otherwise one
// - static idle holds the last bit, or zero at normal polarity
// - uart parity makes the count of ones odd or even as selected
// - free-wheel idle sends the 00110011 line pattern; static idle holds still
// - 12-bit rate field counts N cycles per half period of a square wave
// - each uplink bit takes two divided periods, one per half bit
// - packet length holds words in 29-0 and last-word bytes minus one in 31-30
// - the engine fifo occupancy is readable as a count
module stc_tx_channel #(
  parameter bit UPLINK = 1'b0,
  parameter int DEPTH  = 4
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // register port
  input  wire stc_pkg::stc_req_type reg_req,
  output logic [31:0]               reg_rdata,
  output logic                      reg_rvalid,
  // upstream counts and data
  input  wire logic [15:0]          dma_count,
  input  wire logic                 s_valid,
  output logic                      s_ready,
  input  wire logic [31:0]          s_data,
  // line and interrupt
  output logic                      tx_line,
  output logic                      irq
);
  import stc_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [31:0]   ctrl_q;
  logic [31:0]   len_q;
  logic [31:0]   ae_q;
  logic [31:0]   thr_q;
  logic [31:0]   rxc_q;
  logic          st_done_q;
  logic          st_ae_q;
  logic          st_unf_q;
  logic          ae_le_q;
  logic [31:0]   rdata_q;
  logic          rvalid_q;
  logic          irq_q;
  stc_state_type state_q;
  logic          fvalid;
  logic [31:0]   fdata;
  logic [$clog2(DEPTH+1)-1:0] flevel;

  wire run       = ctrl_q[`STC_B_RUN];
  wire autoclr   = ctrl_q[`STC_B_AUTOCLR];
  wire reverse   = ctrl_q[`STC_B_REVERSE];
  wire byte_mode = ctrl_q[`STC_B_BYTE_MODE];
  wire parity_en = ctrl_q[`STC_B_MODE8];
  wire par_odd   = ctrl_q[`STC_B_MODE9];
  wire stop2     = ctrl_q[`STC_B_MODE10];
  wire static_md = ctrl_q[`STC_B_MODE8];
  wire hold_last = ctrl_q[`STC_B_MODE9];
  wire invert    = ctrl_q[`STC_B_MODE10];
  wire probe     = ctrl_q[`STC_B_PROBE] && !UPLINK;
  wire [11:0] rate = ctrl_q[`STC_RATE_MSB:`STC_RATE_LSB];

  wire wr_ctrl = reg_req.wr && reg_req.addr == `STC_OFS_CTRL;
  wire wr_len  = reg_req.wr && reg_req.addr == `STC_OFS_LEN;
  wire wr_ae   = reg_req.wr && reg_req.addr == `STC_OFS_AE;
  wire wr_thr  = reg_req.wr && reg_req.addr == `STC_OFS_THR;
  wire wr_rxc  = reg_req.wr && reg_req.addr == `STC_OFS_RXCTRL;
  wire wr_st   = reg_req.wr && reg_req.addr == `STC_OFS_STATUS;

  // path count: dma fifo, no external fifo, engine fifo
  wire [31:0] total  = 32'(dma_count) + 32'(flevel);
  wire ae_le         = total <= ae_q;
  wire lvl_now       = total < ae_q;
  wire in_done       = state_q == ST_DONE;
  wire unf_now       = state_q == ST_FETCH && !fvalid && !byte_mode && run;
  wire ae_edge       = ae_le && !ae_le_q;
  wire [31:0] status = {27'h0, state_q != ST_IDLE, lvl_now, st_unf_q, st_ae_q, st_done_q};

  wire [31:0] rd_mux =
    reg_req.addr == `STC_OFS_CTRL   ? ctrl_q :
    reg_req.addr == `STC_OFS_LEN    ? len_q :
    reg_req.addr == `STC_OFS_LEVEL  ? 32'(flevel) :
    reg_req.addr == `STC_OFS_AE     ? ae_q :
    reg_req.addr == `STC_OFS_THR    ? thr_q :
    reg_req.addr == `STC_OFS_RXCTRL ? rxc_q :
    reg_req.addr == `STC_OFS_STATUS ? status : `STC_RST_WORD;

  wire irq_d = (st_done_q && ctrl_q[`STC_B_DONE_EN])
            || (st_ae_q && ctrl_q[`STC_B_AE_EN])
            || (st_unf_q && ctrl_q[`STC_B_UNF_EN])
            || (lvl_now && ctrl_q[`STC_B_LVL_EN]);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ctrl_q <= `STC_RST_WORD;
      len_q  <= `STC_RST_WORD;
      ae_q   <= `STC_RST_WORD;
      thr_q  <= `STC_RST_WORD;
      rxc_q  <= `STC_RST_WORD;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= reg_req.wdata;
      else if (in_done && autoclr)
        ctrl_q[`STC_B_RUN] <= 1'b0;
      if (wr_len)
        len_q <= reg_req.wdata;
      if (wr_ae)
        ae_q <= reg_req.wdata;
      if (wr_thr)
        thr_q <= reg_req.wdata;
      if (wr_rxc)
        rxc_q <= reg_req.wdata;
    end
  end

  // sticky status: write one to clear, a new event wins
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_done_q <= 1'b0;
      st_ae_q   <= 1'b0;
      st_unf_q  <= 1'b0;
      ae_le_q   <= 1'b1;
      irq_q     <= 1'b0;
      rdata_q   <= `STC_RST_WORD;
      rvalid_q  <= 1'b0;
    end
    else
    begin
      st_done_q <= in_done || (st_done_q && !(wr_st && reg_req.wdata[`STC_S_DONE]));
      st_ae_q   <= ae_edge || (st_ae_q && !(wr_st && reg_req.wdata[`STC_S_AE]));
      st_unf_q  <= unf_now || (st_unf_q && !(wr_st && reg_req.wdata[`STC_S_UNF]));
      ae_le_q   <= ae_le;
      irq_q     <= irq_d;
      rdata_q   <= reg_req.rd ? rd_mux : rdata_q;
      rvalid_q  <= reg_req.rd;
    end
  end

  // ****************************************
  // engine fifo
  // ****************************************
  wire pop = state_q == ST_FETCH && fvalid && run;

  stc_fifo #(.W(32), .D(DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (s_valid),
    .in_ready  (s_ready),
    .in_data   (s_data),
    .out_valid (fvalid),
    .out_ready (pop),
    .out_data  (fdata),
    .level     (flevel)
  );

  // ****************************************
  // rate divider
  // ****************************************
  logic [11:0] div_q;
  logic        sq_q;
  logic        tick_q;
  wire [11:0]  n_m1 = rate == 12'h000 ? 12'h000 : rate - 12'h001;
  wire         wrap = div_q >= n_m1;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      div_q  <= 12'h000;
      sq_q   <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q  <= wrap ? 12'h000 : div_q + 12'h001;
      sq_q   <= wrap ? !sq_q : sq_q;
      tick_q <= wrap && !sq_q;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  logic [29:0] words_q;
  logic [2:0]  bytes_q;
  logic [31:0] word_q;
  logic [11:0] sh_q;
  logic [3:0]  bits_q;
  logic        half_q;
  logic [1:0]  idle_q;
  logic        line_q;

  wire [7:0] lane    = reverse ? word_q[31:24] : word_q[7:0];
  wire [31:0] nxt_wd = reverse ? word_q << 8 : word_q >> 8;
  wire       par     = par_odd ? ~^lane : ^lane;
  wire [11:0] ufrm   = parity_en ? {2'b11, par, lane, 1'b0} : {3'b111, lane, 1'b0};
  wire [3:0] ubits   = `STC_UART_BASE + 4'(parity_en) + 4'(stop2);
  wire [7:0] rlane   = {<<{lane}};
  wire       last_w  = words_q == 30'h1;
  wire [2:0] nbytes  = byte_mode ? 3'h1 :
                       last_w ? 3'(len_q[`STC_LEN_LAST]) + 3'h1 : 3'h4;
  wire       bit_end = tick_q && (!UPLINK || half_q);
  wire       frm_end = state_q == ST_SEND && bit_end && bits_q == 4'h1;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      words_q <= 30'h0;
      bytes_q <= 3'h0;
      word_q  <= `STC_RST_WORD;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (run)
            state_q <= ST_HOLD;
        ST_HOLD:
          if (!run)
            state_q <= ST_IDLE;
          else if (total >= thr_q)
          begin
            words_q <= len_q[`STC_LEN_WORDS];
            state_q <= (!byte_mode && len_q[`STC_LEN_WORDS] == 30'h0) ? ST_DONE : ST_FETCH;
          end
        ST_FETCH:
          if (!run)
            state_q <= ST_IDLE;
          else if (fvalid)
          begin
            word_q  <= fdata;
            bytes_q <= nbytes;
            state_q <= ST_BYTE;
          end
        ST_BYTE:
          state_q <= ST_SEND;
        ST_SEND:
          if (frm_end)
          begin
            bytes_q <= bytes_q - 3'h1;
            word_q  <= nxt_wd;
            if (bytes_q > 3'h1 && run)
              state_q <= ST_BYTE;
            else if (!run)
              state_q <= ST_IDLE;
            else if (byte_mode || last_w)
              state_q <= ST_DONE;
            else
            begin
              words_q <= words_q - 30'h1;
              state_q <= ST_FETCH;
            end
          end
        ST_DONE:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // line encoder
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sh_q   <= 12'h000;
      bits_q <= 4'h0;
      half_q <= 1'b0;
      idle_q <= 2'b00;
      line_q <= !UPLINK;
    end
    else if (state_q == ST_BYTE)
    begin
      sh_q   <= UPLINK ? {4'h0, rlane} : ufrm;
      bits_q <= UPLINK ? `STC_UPL_BITS : ubits;
      half_q <= 1'b0;
    end
    else if (probe)
      line_q <= sq_q;
    else if (tick_q && state_q == ST_SEND)
    begin
      if (UPLINK)
        line_q <= (sh_q[0] ^ half_q) ^ invert;
      else
        line_q <= sh_q[0];
      half_q <= UPLINK && !half_q;
      if (bit_end)
      begin
        sh_q   <= sh_q >> 1;
        bits_q <= bits_q - 4'h1;
      end
    end
    else if (tick_q)
    begin
      idle_q <= idle_q + 2'h1;
      if (!UPLINK)
        line_q <= 1'b1;
      else if (!static_md)
        line_q <= idle_q[1] ^ invert;
      else if (!hold_last)
        line_q <= invert;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign tx_line    = line_q;
  assign irq        = irq_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_run_gates_start: assert property (
    state_q == ST_IDLE && !run |=> state_q == ST_IDLE)
    else $error("sequencer left idle without run");
  a_hold_threshold: assert property (
    state_q == ST_HOLD && total < thr_q |=> state_q != ST_FETCH)
    else $error("started below threshold");
  a_autoclr_run: assert property (
    in_done && autoclr && !wr_ctrl |=> !run)
    else $error("run not auto-cleared");
  a_done_sets: assert property (
    in_done |=> st_done_q)
    else $error("done status missing");
  a_ae_edge_set: assert property (
    ae_le && !ae_le_q |=> st_ae_q)
    else $error("almost-empty edge lost");
  a_unf_sticky: assert property (
    unf_now |=> st_unf_q)
    else $error("underflow not flagged");
  a_unf_irq: assert property (
    st_unf_q && ctrl_q[`STC_B_UNF_EN] |=> irq_q)
    else $error("underflow irq missing");
  a_lvl_irq: assert property (
    lvl_now && ctrl_q[`STC_B_LVL_EN] |=> irq_q)
    else $error("level irq missing");
  a_probe_line: assert property (
    probe && state_q != ST_BYTE |=> line_q == $past(sq_q))
    else $error("probe clock not on line");
  a_stop_gap: assert property (
    !UPLINK && frm_end && !probe |-> (line_q || !stop2) ##1 line_q)
    else $error("stop bit missing");
endmodule // stc_tx_channel

// ===== testbench/stc_uart_rx_model.sv
// uart receiver model standing on the far end of the tx line
`timescale 1ns/1ps

module stc_uart_rx_model #(
  parameter int BIT = 8
) (
  // clock and line
  input  wire logic       clk_sys,
  input  wire logic       tx_line,
  // frame format
  input  wire logic       par_en,
  input  wire logic       par_odd,
  // received characters
  output logic [7:0]      rx_byte,
  output logic            rx_err,
  output logic            rx_stb
);
  logic [7:0] sh;
  logic       err;
  initial
  begin
    rx_byte = 8'h00;
    rx_err  = 1'b0;
    rx_stb  = 1'b0;
    forever
    begin
      @(negedge tx_line);
      repeat (BIT / 2) @(posedge clk_sys);
      err = tx_line;
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT) @(posedge clk_sys);
        sh[i] = tx_line;
      end
      if (par_en)
      begin
        repeat (BIT) @(posedge clk_sys);
        err = err | ((^{sh, tx_line}) != par_odd);
      end
      repeat (BIT) @(posedge clk_sys);
      err = err | !tx_line;
      rx_byte <= sh;
      rx_err  <= err;
      rx_stb  <= 1'b1;
      @(posedge clk_sys);
      rx_stb  <= 1'b0;
    end
  end
endmodule // stc_uart_rx_model

// ===== testbench/testbench.sv
// self-checking bench for the uart build of the tx channel control
`timescale 1ns/1ps

module testbench;
  import stc_pkg::*;
  // ****************
  // signals
  // ****************
  logic                 clk_sys;
  logic                 sys_rst;
  stc_req_type          reg_req;
  logic [31:0]          reg_rdata;
  logic                 reg_rvalid;
  logic [15:0]          dma_count;
  logic                 s_valid;
  logic                 s_ready;
  logic [31:0]          s_data;
  logic                 tx_line;
  logic                 irq;
  logic                 par_en;
  logic                 par_odd;
  logic [7:0]           rx_byte;
  logic                 rx_err;
  logic                 rx_stb;
  logic [8:0]           got[$];
  logic                 prev;
  int                   n_mismatch;
  int                   tests_run;
  int                   k;
  logic [7:0]           addrs [8] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h34, 8'h38, 8'h40};
  logic [7:0]           bytes [4] = '{8'ha5, 8'h3c, 8'hff, 8'h00};
  localparam logic [31:0] RATE4 = 32'h0004_0000;

  stc_tx_channel #(.UPLINK(1'b0), .DEPTH(4)) u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .dma_count(dma_count), .s_valid(s_valid),
    .s_ready(s_ready), .s_data(s_data), .tx_line(tx_line), .irq(irq));

  stc_uart_rx_model #(.BIT(8)) u_rx (
    .clk_sys(clk_sys), .tx_line(tx_line), .par_en(par_en), .par_odd(par_odd),
    .rx_byte(rx_byte), .rx_err(rx_err), .rx_stb(rx_stb));

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (rx_stb === 1'b1)
      got.push_back({rx_err, rx_byte});

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys);
    reg_req.wr = 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk_sys);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(negedge clk_sys);
    reg_req.rd = 1'b0;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hdead_beef;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rdr(a, v);
    chk(v & m, e);
  endtask
  task automatic push(input logic [31:0] d);
    int i;
    @(negedge clk_sys);
    s_valid = 1'b1;
    s_data  = d;
    for (i = 0; i < 50 && s_ready !== 1'b1; i++)
      @(negedge clk_sys);
    if (i == 50)
      chk(32'h0, 32'h1);
    @(negedge clk_sys);
    s_valid = 1'b0;
  endtask
  task automatic getb(input logic [7:0] e);
    int i;
    for (i = 0; i < 3000 && got.size() == 0; i++)
      @(negedge clk_sys);
    chk({23'h0, (got.size() > 0) ? got.pop_front() : 9'h1ff}, {24'h0, e});
  endtask
  task automatic results;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************
  // sequence
  // ****************
  initial
  begin
    #500_000;
    n_mismatch++;
    results();
  end

  initial
  begin
    sys_rst = 1'b1;
    reg_req = '0;
    dma_count = 16'h0;
    s_valid = 1'b0;
    s_data = 32'h0;
    par_en = 1'b0;
    par_odd = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    // reset values, unmapped read, readback, read-only level
    for (int i = 0; i < 8; i++)
      rc(addrs[i], 32'hffff_ffff, 32'h0);
    for (int i = 1; i < 6; i++)
    begin
      wr(addrs[i], 32'ha5a5_0000 + i);
      rc(addrs[i], 32'hffff_ffff, (addrs[i] == 8'h24) ? 32'h0 : 32'ha5a5_0000 + i);
      wr(addrs[i], 32'h0);
    end
    // fill fifo with run clear until it refuses
    for (int i = 0; i < 4; i++)
      push({24'h0, bytes[i]});
    @(negedge clk_sys);
    chk({31'h0, s_ready}, 32'h0);
    rc(8'h24, 32'hffff_ffff, 32'h4);
    repeat (200) @(negedge clk_sys);
    chk(32'(got.size()), 32'h0);
    chk({31'h0, tx_line}, 32'h1);
    // byte mode, odd parity, drain to empty
    par_en = 1'b1;
    par_odd = 1'b1;
    wr(8'h1c, 32'h0000_0385 | RATE4);
    for (int i = 0; i < 4; i++)
      getb(bytes[i]);
    repeat (40) @(negedge clk_sys);
    rc(8'h38, 32'h7, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(8'h38, 32'h7);
    rc(8'h38, 32'h7, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // reversed lanes, even parity, two stops
    par_odd = 1'b0;
    wr(8'h1c, 32'h0000_05a1 | RATE4);
    push(32'h5a00_0011);
    getb(8'h5a);
    // packet mode held off by threshold, then auto-clear
    wr(8'h1c, 32'h0);
    par_en = 1'b0;
    wr(8'h20, 32'h4000_0001);
    wr(8'h2c, 32'h2);
    wr(8'h1c, 32'h0000_0003 | RATE4);
    push(32'h4433_2211);
    repeat (300) @(negedge clk_sys);
    chk(32'(got.size()), 32'h0);
    dma_count = 16'h1;
    getb(8'h11);
    getb(8'h22);
    dma_count = 16'h0;
    repeat (200) @(negedge clk_sys);
    chk(32'(got.size()), 32'h0);
    rc(8'h1c, 32'h1, 32'h0);
    // level interrupt below almost-empty total
    wr(8'h2c, 32'h0);
    wr(8'h28, 32'h3);
    wr(8'h1c, 32'h40);
    repeat (4) @(negedge clk_sys);
    rc(8'h38, 32'h8, 32'h8);
    chk({31'h0, irq}, 32'h1);
    wr(8'h1c, 32'h0);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    wr(8'h28, 32'h0);
    // underflow in mid packet
    wr(8'h20, 32'hc000_0002);
    wr(8'h1c, 32'h0000_0011 | RATE4);
    push(32'h4433_2211);
    for (int i = 1; i < 5; i++)
      getb(8'(i * 8'h11));
    repeat (20) @(negedge clk_sys);
    rc(8'h38, 32'h4, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr(8'h1c, RATE4);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rc(8'h38, 32'h4, 32'h4);
    wr(8'h38, 32'h4);
    rc(8'h38, 32'h4, 32'h0);
    rc(8'h38, 32'h10, 32'h0);
    // reference clock probe on the line
    wr(8'h1c, 32'h0001_0800);
    k = 0;
    prev = tx_line;
    repeat (16)
    begin
      @(negedge clk_sys);
      if (tx_line !== prev)
        k++;
      prev = tx_line;
    end
    chk({31'h0, k >= 4}, 32'h1);
    results();
  end
endmodule // testbench
